// ===== logic/i2c_bus_mode_control.sv
`timescale 1ns/100ps
`include "bus_mode_defines.svh"
module i2c_bus_mode_control import bus_mode_pkg::*; #(
    parameter int XFER_DIV = 8,
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic order_q, wait_q, fmt_q, master_q, ack_q;
    logic [2:0] count_q;
    logic [3:0] bits_q, bits_d;
    logic [1:0] stall_cnt_q;
    logic [15:0] tick_cnt_q;
    logic [31:0] prdata_q;
    xfer_state_t state_q, state_d;
    logic out_bit;
    logic [W-1:0] rx_data;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire sel_bmc = paddr == `OFS_BUS_MODE;
    wire sel_ctrl = paddr == `OFS_CTRL;
    wire sel_data = paddr == `OFS_DATA;
    wire sel_stat = paddr == `OFS_STATUS;
    wire mapped = sel_bmc | sel_ctrl | sel_data | sel_stat;
    wire wr_bmc = access & pwrite & sel_bmc;
    wire idle = state_q == ST_IDLE;
    // ctrl bits are frozen during a transfer so the sequencer never sees them move; wr_bmc is not gated by idle
    wire wr_ctrl = access & pwrite & sel_ctrl & idle;
    wire start = access & pwrite & sel_data & idle;
    wire cnt_wr = wr_bmc & ~pwdata[`BMC_WP_BIT];

    // zero-wait slave; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // bits 5:3 are constant ones, nothing written there is stored
    wire [7:0] bmc_rd = {order_q, wait_q, `BMC_ONES, count_q};
    wire [31:0] ctrl_rd = {30'h0, master_q, fmt_q};
    wire [31:0] stat_rd = {30'h0, ack_q, ~idle};
    wire [31:0] rd_mux = sel_bmc ? {24'h0, bmc_rd} :
                         sel_ctrl ? ctrl_rd :
                         sel_data ? {{(32-W){1'b0}}, rx_data} :
                         sel_stat ? stat_rd : 32'h0;

    // read data is captured in the setup cycle, so it is a flop in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // ----------------------------------------
    // transfer clock divider
    // ----------------------------------------
    wire tick = tick_cnt_q == 16'(XFER_DIV - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 16'h0;
        end else begin
            tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    // two-wire format counts the ack bit on top of the data bits
    function automatic logic [3:0] bit_total(input logic [2:0] cnt, input logic two_wire);
        logic [3:0] n;
        n = {1'b0, cnt};
        if (two_wire) begin
            bit_total = (cnt == 3'h0) ? `BITS_TWO_WIRE_FULL : n + 4'h1;
        end else begin
            bit_total = (cnt == 3'h0) ? `BITS_SYNC_FULL : n;
        end
    endfunction

    wire last_bit = bits_q == `BITS_LAST;
    wire ack_phase = fmt_q & last_bit;
    wire wait_on = wait_q & master_q & fmt_q;
    wire stall_now = wait_on & (bits_q == `BITS_ACK_NEXT);
    wire bit_end = (state_q == ST_HIGH) & tick;
    wire done = bit_end & last_bit;
    wire stall_end = (state_q == ST_STALL) & tick & (stall_cnt_q == `WAIT_TICKS - 2'h1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) state_d = ST_LOW;
            end
            ST_LOW: begin
                if (tick) state_d = ST_HIGH;
            end
            ST_HIGH: begin
                if (tick) begin
                    if (last_bit) state_d = ST_IDLE;
                    else if (stall_now) state_d = ST_STALL;
                    else state_d = ST_LOW;
                end
            end
            ST_STALL: begin
                if (stall_end) state_d = ST_LOW;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    assign bits_d = start ? bit_total(count_q, fmt_q) : (bit_end ? bits_q - 4'h1 : bits_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            bits_q <= 4'h0;
            stall_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            bits_q <= bits_d;
            stall_cnt_q <= (state_q == ST_STALL) ? stall_cnt_q + {1'b0, tick} : 2'h0;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // a write that clears the protect bit beats the end-of-transfer reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            order_q <= `BMC_ORDER_RST;
            wait_q <= `BMC_WAIT_RST;
            count_q <= `BMC_CNT_RST;
        end else begin
            if (wr_bmc) order_q <= pwdata[`BMC_ORDER_BIT];
            if (wr_bmc) wait_q <= pwdata[`BMC_WAIT_BIT];
            if (cnt_wr) count_q <= pwdata[`BMC_CNT_HI:0];
            else if (done) count_q <= `BMC_CNT_RELOAD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= `CTRL_FMT_RST;
            master_q <= `CTRL_MASTER_RST;
            ack_q <= 1'b0;
        end else begin
            if (wr_ctrl) fmt_q <= pwdata[`CTRL_FMT_BIT];
            if (wr_ctrl) master_q <= pwdata[`CTRL_MASTER_BIT];
            if (bit_end && ack_phase) ack_q <= sda_i;
        end
    end

    bit_shifter #(.W(W)) u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .load(start),
        .load_data(pwdata[W-1:0]),
        .shift(bit_end & ~ack_phase),
        .in_bit(sda_i),
        .lsb_first(order_q),
        .out_bit(out_bit),
        .data(rx_data)
    );

    // ----------------------------------------
    // open-drain pins
    // ----------------------------------------
    // scl only driven as master; slave timing still comes from the internal tick, scl_i is not used
    assign scl_o = 1'b0;
    assign scl_oe = master_q & ((state_q == ST_LOW) | (state_q == ST_STALL));
    assign sda_o = 1'b0;
    assign sda_oe = ~idle & ~ack_phase & ~out_bit;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence last_data_end_s;
        bit_end && bits_q == `BITS_ACK_NEXT && fmt_q && master_q;
    endsequence

    wait_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
        last_data_end_s ##0 wait_q |=> (state_q == ST_STALL && scl_oe)[*2])
        else $error("wait did not hold scl low after the last data bit");
    stall_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_STALL |-> stall_cnt_q < `WAIT_TICKS)
        else $error("stall ran past two transfer clocks");
    no_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        last_data_end_s ##0 !wait_q |=> state_q == ST_LOW)
        else $error("ack delayed although wait is clear");
    wait_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_STALL |-> master_q && fmt_q)
        else $error("wait inserted in slave or synchronous format");
    reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_bmc |=> prdata[5:4] == 2'h3)
        else $error("reserved bits did not read one");
    protect_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_bmc && pwdata[`BMC_WP_BIT] && !done |=> $stable(count_q))
        else $error("protected write changed the counter");
    protect_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_wr |=> count_q == $past(pwdata[2:0]))
        else $error("unprotected write did not load the counter");
    protect_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_bmc |=> prdata[3])
        else $error("protect bit did not read one");
    reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !cnt_wr |=> count_q == `BMC_CNT_RELOAD && state_q == ST_IDLE)
        else $error("counter not reloaded at end of transfer");
    discard_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_bmc |=> bmc_rd[5:3] == `BMC_ONES)
        else $error("reserved or protect bit stored a write");
endmodule // i2c_bus_mode_control

// ===== logic/bus_mode_defines.svh
`ifndef BUS_MODE_DEFINES_SVH
`define BUS_MODE_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_BUS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_DATA 8'h08
`define OFS_STATUS 8'h0C

// ----------------------------------------
// bus_mode_control fields
// ----------------------------------------
`define BMC_ORDER_BIT 7
`define BMC_WAIT_BIT 6
`define BMC_WP_BIT 3
`define BMC_CNT_HI 2
`define BMC_ONES 3'h7
`define BMC_ORDER_RST 1'h0
`define BMC_WAIT_RST 1'h0
`define BMC_CNT_RST 3'h0
`define BMC_CNT_RELOAD 3'h0

// ----------------------------------------
// ctrl and status fields
// ----------------------------------------
`define CTRL_FMT_BIT 0
`define CTRL_MASTER_BIT 1
`define CTRL_FMT_RST 1'h1
`define CTRL_MASTER_RST 1'h1
`define STAT_BUSY_BIT 0
`define STAT_ACK_BIT 1

// ----------------------------------------
// transfer timing
// ----------------------------------------
`define WAIT_TICKS 2'h2
`define BITS_TWO_WIRE_FULL 4'h9
`define BITS_SYNC_FULL 4'h8
`define BITS_LAST 4'h1
`define BITS_ACK_NEXT 4'h2

`endif

// ===== logic/bus_mode_pkg.sv
package bus_mode_pkg;
    // one-hot transfer sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOW = 4'h2,
        ST_HIGH = 4'h4,
        ST_STALL = 4'h8
    } xfer_state_t;
endpackage

// ===== logic/bit_shifter.sv
`timescale 1ns/100ps
module bit_shifter #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] load_data,
    input wire logic shift,
    input wire logic in_bit,
    input wire logic lsb_first,
    output logic out_bit,
    output logic [W-1:0] data
);
    // ----------------------------------------
    // shift register
    // ----------------------------------------
    logic [W-1:0] sh_q;
    wire [W-1:0] sh_msb = {sh_q[W-2:0], in_bit};
    wire [W-1:0] sh_lsb = {in_bit, sh_q[W-1:1]};
    wire [W-1:0] sh_d = load ? load_data : (shift ? (lsb_first ? sh_lsb : sh_msb) : sh_q);

    // current bit on the wire comes from the end picked by the order select
    assign out_bit = lsb_first ? sh_q[0] : sh_q[W-1];
    assign data = sh_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    msb_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
        (shift && !load && !lsb_first) |=> sh_q == {$past(sh_q[W-2:0]), $past(in_bit)})
        else $error("msb-first shift moved the wrong way");
    lsb_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
        (shift && !load && lsb_first) |=> sh_q == {$past(in_bit), $past(sh_q[W-1:1])})
        else $error("lsb-first shift moved the wrong way");
endmodule // bit_shifter

// ===== sim/bus_partner.sv
`timescale 1ns/100ps
// ------------
// partner
// ------------
// two-wire slave: samples each bit on the rising clock, acks one slot
module bus_partner (
    input wire logic scl,
    input wire logic sda,
    input wire logic clr,
    input wire logic [3:0] ack_idx,
    output logic sda_pull,
    output logic [3:0] nrise,
    output logic [15:0] rx,
    output logic [15:0] low_ns
);
    realtime t_fall;
    // clr releases sda, since the clock stays high once the frame ends
    always @(negedge scl or posedge clr) begin
        if (clr) begin
            sda_pull <= 1'b0;
        end else begin
            t_fall = $realtime;
            sda_pull <= (nrise == ack_idx);
        end
    end
    // shift in each bit and keep the length of the low phase just ended
    always @(posedge scl or posedge clr) begin
        if (clr) begin
            nrise <= 4'h0;
            rx <= 16'h0;
        end else begin
            nrise <= nrise + 4'h1;
            rx <= {rx[14:0], sda};
            low_ns <= 16'(int'($realtime - t_fall));
        end
    end
endmodule // bus_partner

// ===== sim/i2c_bus_mode_control_tb.sv
`timescale 1ns/100ps
`include "bus_mode_defines.svh"
module i2c_bus_mode_control_tb;
    // short tick keeps every frame under a hundred cycles
    localparam int DIV = 4;
    // clr starts low so the first frame gives the partner a real rising edge to clear on
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, scl_o, scl_oe, sda_o, sda_oe, pull;
    logic [3:0] ack_idx = 4'hF, nrise;
    logic [15:0] rx, low_ns;
    int bad_count = 0, checks_done = 0, cyc = 0;
    // open-drain wires with pull-ups
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | pull);

    i2c_bus_mode_control #(.XFER_DIV(DIV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    bus_partner i_peer (.scl(scl), .sda(sda), .clr(clr), .ack_idx(ack_idx), .sda_pull(pull),
        .nrise(nrise), .rx(rx), .low_ns(low_ns));

    always #5 pclk = ~pclk;
    // watchdog cuts a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ------------
    // helpers
    // ------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a frame and poll until idle; rd keeps the last status
    task automatic xfer(input logic [7:0] d, input logic [3:0] ai);
        int n;
        ack_idx = ai;
        clr = 1'b1;
        #1;
        clr = 1'b0;
        apb(1'b1, `OFS_DATA, {24'h0, d});
        n = 0;
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------
    // scenarios
    // ------------
    task t_regs;
        apb(1'b0, `OFS_BUS_MODE, 32'h0);
        chk("mode reset", 32'h38, rd);
        chk("pin levels", 32'h0, {30'h0, scl_o, sda_o});
        apb(1'b1, `OFS_BUS_MODE, 32'h4F);
        apb(1'b0, `OFS_BUS_MODE, 32'h0);
        chk("mode protected", 32'h78, rd);
        apb(1'b1, `OFS_BUS_MODE, 32'h05);
        apb(1'b0, `OFS_BUS_MODE, 32'h0);
        chk("mode count", 32'h3D, rd);
        apb(1'b1, 8'h10, 32'hFF);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("test registers done");
    endtask
    task t_partial;
        apb(1'b1, `OFS_BUS_MODE, 32'h03);
        xfer(8'hA5, 4'h3);
        chk("partial bits", 32'h4, {28'h0, nrise});
        chk("partial data", 32'hA, {28'h0, rx[3:0]});
        chk("ack seen", 32'h0, {31'h0, rd[1]});
        apb(1'b0, `OFS_BUS_MODE, 32'h0);
        chk("count reload", 32'h38, rd);
        $display("test partial done");
    endtask
    task t_wait(input logic [31:0] mode, input logic [3:0] ai, input int ticks);
        apb(1'b1, `OFS_BUS_MODE, mode);
        xfer(8'hC3, ai);
        chk("bits", 32'h9, {28'h0, nrise});
        chk("data", {23'h0, 8'hC3, ai == 4'hF}, {23'h0, rx[8:0]});
        chk("ack level", {31'h0, ai == 4'hF}, {31'h0, rd[1]});
        chk("ack low", ticks * DIV * 10, {16'h0, low_ns});
        $display("test wait done");
    endtask
    task t_sync;
        apb(1'b1, `OFS_CTRL, 32'h2);
        apb(1'b1, `OFS_BUS_MODE, 32'hC0);
        xfer(8'h01, 4'hF);
        chk("sync bits", 32'h8, {28'h0, nrise});
        chk("lsb first", 32'h80, {24'h0, rx[7:0]});
        chk("sync low", DIV * 10, {16'h0, low_ns});
        apb(1'b0, `OFS_DATA, 32'h0);
        chk("data read", 32'h01, rd);
        $display("test sync done");
    endtask
    // slave keeps scl released and never stalls, so the frame stays at 18 half bits
    task t_slave;
        int t0;
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b1, `OFS_BUS_MODE, 32'h40);
        t0 = cyc;
        xfer(8'h5A, 4'hF);
        chk("slave scl edges", 32'h0, {28'h0, nrise});
        chk("slave no stall", 32'h1, {31'h0, (cyc - t0) < 20 * DIV});
        $display("test slave done");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_partial();
        t_wait(32'h00, 4'h8, 1);
        t_wait(32'h40, 4'hF, 3);
        t_slave();
        t_sync();
        end_of_test();
    end
endmodule // i2c_bus_mode_control_tb
